/* File: logic/thermostat_alarm_logic.sv */
/*
  Thermostat alarm block with an Avalon-MM register slave.
  Assumes one 40 MHz clock and conversion results from a sensor core.
*/
// Summary of operation
// - A1h selects upper, A2h lower limit
// - Alarm active when temperature exceeds upper limit
// - Sense one: active high, inactive low
// - Sense zero: active low, inactive high
// - Flag sets when temperature exceeds upper limit
// - Flag holds until temperature below lower limit
// - AAh returns latest conversion result, repeatable
// - Mode field gates alarm; flags always work
// - Sticky latch set on first alarm, reset-only
`timescale 1ns/10ps
`default_nettype none
`include "thermo_defines.svh"
module thermostat_alarm_logic (
  input wire logic I_CLK,
  input wire logic I_ARST_N,
  input wire thermo_pkg::avs_req_s I_AVS,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire thermo_pkg::conv_s I_CONV,
  input wire logic I_TIME_ALARM,
  output logic O_ALARM_OUTPUT,
  output logic O_IRQ
);
  import thermo_pkg::*;

  logic [7:0] cmd;
  logic [15:0] upper_limit;
  logic [15:0] lower_limit;
  logic [15:0] temp;
  cfg_s cfg;
  logic [`IRQ_W-1:0] irq_status;
  logic [`IRQ_W-1:0] irq_mask;
  logic [`IRQ_W-1:0] next_irq_status;
  logic [`IRQ_W-1:0] next_irq_mask;
  logic heat_next;
  logic heat_alarm_flag;
  logic sticky_heat_latch;
  logic set_evt;
  logic clr_evt;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0] be);
    merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // Bus decode
  wire req_new;
  wire accept_wr;
  wire sel_cmd;
  wire sel_data;
  wire sel_cfg;
  wire sel_sts;
  wire sel_msk;
  wire lane0;
  wire is_upper;
  wire is_lower;
  wire is_temp;
  wire ld_upper;
  wire ld_lower;
  wire [15:0] data_view;
  wire [31:0] rd_mux;
  wire [`IRQ_W-1:0] events;
  wire [`IRQ_W-1:0] w1c;
  wire active_next;
  wire alarm_next;

  assign req_new = (I_AVS.read | I_AVS.write) & O_AVS_WAITREQUEST;
  assign accept_wr = I_AVS.write & ~O_AVS_WAITREQUEST;
  assign sel_cmd = I_AVS.address == `OFS_CMD;
  assign sel_data = I_AVS.address == `OFS_DATA;
  assign sel_cfg = I_AVS.address == `OFS_CFG;
  assign sel_sts = I_AVS.address == `OFS_IRQ_STATUS;
  assign sel_msk = I_AVS.address == `OFS_IRQ_MASK;
  assign lane0 = I_AVS.byteenable[0];

  // Command register steers what the data window reaches
  assign is_upper = cmd == `CMD_UPPER_LIMIT;
  assign is_lower = cmd == `CMD_LOWER_LIMIT;
  assign is_temp = cmd == `CMD_READ_TEMP;
  // Temperature is read-only: a data write under AAh is dropped
  assign ld_upper = accept_wr & sel_data & is_upper;
  assign ld_lower = accept_wr & sel_data & is_lower;

  assign data_view = is_upper ? upper_limit :
                     is_lower ? lower_limit :
                     is_temp ? temp : 16'h0000;

  assign rd_mux = sel_cmd ? {24'h00_0000, cmd} :
                  sel_data ? {16'h0000, data_view} :
                  sel_cfg ? {27'h000_0000, sticky_heat_latch, heat_alarm_flag, cfg.mode, cfg.sense} :
                  sel_sts ? {29'h0000_0000, irq_status} :
                  sel_msk ? {29'h0000_0000, irq_mask} : 32'h0000_0000;

  heat_comparator i_heat_comparator (
    .i_clk(I_CLK),
    .i_arst_n(I_ARST_N),
    .i_conv(I_CONV),
    .i_upper(upper_limit),
    .i_lower(lower_limit),
    .o_next_flag(heat_next),
    .o_flag(heat_alarm_flag),
    .o_latch(sticky_heat_latch),
    .o_set(set_evt),
    .o_clr(clr_evt)
  );

  // Output built from the flag's next value so both move on one edge
  assign active_next = (cfg.mode[0] & heat_next) | (cfg.mode[1] & I_TIME_ALARM);
  assign alarm_next = cfg.sense ? active_next : ~active_next;

  // Answer one cycle after the request is seen
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_AVS_WAITREQUEST <= 1'b1;
    end else begin
      O_AVS_WAITREQUEST <= ~req_new;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_AVS_READDATA <= 32'h0000_0000;
    end else if (I_AVS.read & O_AVS_WAITREQUEST) begin
      O_AVS_READDATA <= rd_mux;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cmd <= `CMD_RST;
    end else if (accept_wr & sel_cmd & lane0) begin
      cmd <= I_AVS.writedata[7:0];
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      upper_limit <= `UPPER_RST;
      lower_limit <= `LOWER_RST;
    end else begin
      if (ld_upper) begin
        upper_limit <= merge16(upper_limit, I_AVS.writedata[15:0], I_AVS.byteenable[1:0]);
      end
      if (ld_lower) begin
        lower_limit <= merge16(lower_limit, I_AVS.writedata[15:0], I_AVS.byteenable[1:0]);
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      temp <= `TEMP_RST;
    end else if (I_CONV.valid) begin
      temp <= I_CONV.temp;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cfg.sense <= `SENSE_RST;
      cfg.mode <= `MODE_RST;
      irq_mask <= `IRQ_RST;
    end else begin
      if (accept_wr & sel_cfg & lane0) begin
        cfg.sense <= I_AVS.writedata[`CFG_SENSE_BIT];
        cfg.mode <= I_AVS.writedata[`CFG_MODE_HI:`CFG_MODE_LO];
      end
      irq_mask <= next_irq_mask;
    end
  end

  // Interrupt status: a new event beats a clear in the same cycle
  assign events[`IRQ_FLAG_SET] = set_evt;
  assign events[`IRQ_FLAG_CLR] = clr_evt;
  assign events[`IRQ_CONV] = I_CONV.valid;
  assign w1c = (accept_wr & sel_sts & lane0) ? I_AVS.writedata[`IRQ_W-1:0] : '0;
  // New mask used at once so the interrupt pin never lags a mask write
  assign next_irq_mask = (accept_wr & sel_msk & lane0) ?
                         I_AVS.writedata[`IRQ_W-1:0] : irq_mask;

  genvar b;
  generate
    for (b = 0; b < `IRQ_W; b++) begin : g_irq
      assign next_irq_status[b] = events[b] | (irq_status[b] & ~w1c[b]);
    end
  endgenerate

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      irq_status <= `IRQ_RST;
      O_IRQ <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      O_IRQ <= |(next_irq_status & next_irq_mask);
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_ALARM_OUTPUT <= `ALARM_RST;
    end else begin
      O_ALARM_OUTPUT <= alarm_next;
    end
  end

  // Checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_ARST_N);

  wire hot_in = I_CONV.valid & ($signed(I_CONV.temp) > $signed(upper_limit));
  wire cold_in = I_CONV.valid & ($signed(I_CONV.temp) < $signed(lower_limit));
  wire full_be = I_AVS.byteenable[1:0] == 2'b11;
  wire sel_none = ~(sel_cmd | sel_data | sel_cfg | sel_sts | sel_msk);

  upper_load_a: assert property (
    accept_wr & sel_data & is_upper & full_be |=> upper_limit == $past(I_AVS.writedata[15:0])
  ) else $error("upper limit not loaded");

  lower_load_a: assert property (
    accept_wr & sel_data & is_lower & full_be |=> lower_limit == $past(I_AVS.writedata[15:0])
  ) else $error("lower limit not loaded");

  alarm_hot_a: assert property (
    hot_in & cfg.mode == 2'b01 & cfg.sense |=> O_ALARM_OUTPUT
  ) else $error("alarm not active above upper limit");

  sense_high_a: assert property (
    cfg.sense & cfg.mode == 2'b01 & ~heat_next |=> !O_ALARM_OUTPUT
  ) else $error("active-high output not low when inactive");

  sense_low_a: assert property (
    !cfg.sense & cfg.mode == 2'b01 & hot_in |=> !O_ALARM_OUTPUT
  ) else $error("active-low output not low when active");

  flag_set_a: assert property (
    hot_in |=> heat_alarm_flag ##0 sticky_heat_latch
  ) else $error("flag not set above upper limit");

  flag_hold_a: assert property (
    heat_alarm_flag & ~cold_in |=> heat_alarm_flag
  ) else $error("flag dropped without cold sample");

  flag_clear_a: assert property (
    heat_alarm_flag & cold_in & ~hot_in |=> !heat_alarm_flag
  ) else $error("flag not cleared below lower limit");

  temp_read_a: assert property (
    I_AVS.read & O_AVS_WAITREQUEST & sel_data & is_temp
      |=> !O_AVS_WAITREQUEST && O_AVS_READDATA[15:0] == $past(temp)
  ) else $error("temperature read mismatch");

  mode_off_a: assert property (
    cfg.mode == 2'b00 |=> O_ALARM_OUTPUT == !$past(cfg.sense)
  ) else $error("disabled alarm output not inactive");

  time_only_a: assert property (
    cfg.mode == 2'b10 & I_TIME_ALARM |=> O_ALARM_OUTPUT == $past(cfg.sense)
  ) else $error("time alarm not passed through");

  latch_keep_a: assert property (
    sticky_heat_latch |=> sticky_heat_latch [*3]
  ) else $error("sticky latch cleared");

  clear_sync_a: assert property (
    $fell(heat_alarm_flag) & $past(cfg.mode == 2'b01) |-> O_ALARM_OUTPUT == !$past(cfg.sense)
  ) else $error("alarm output did not clear with flag");

  wait_answer_a: assert property (
    req_new |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST
  ) else $error("bus answer not one cycle");

  irq_level_a: assert property (
    (irq_status & irq_mask) != '0 |-> O_IRQ
  ) else $error("interrupt low with unmasked status");

  irq_low_a: assert property (
    (irq_status & irq_mask) == '0 |-> !O_IRQ
  ) else $error("interrupt high with nothing unmasked");

  status_set_a: assert property (
    events != '0 |=> (irq_status & $past(events)) == $past(events)
  ) else $error("status event lost");

  w1c_clear_a: assert property (
    (w1c & ~events) != '0 |=> (irq_status & $past(w1c & ~events)) == '0
  ) else $error("status bit not cleared by write");

  cmd_load_a: assert property (
    accept_wr & sel_cmd & lane0 |=> cmd == $past(I_AVS.writedata[7:0])
  ) else $error("command code not loaded");

  upper_keep_a: assert property (
    !ld_upper |=> upper_limit == $past(upper_limit)
  ) else $error("upper limit changed without load");

  lower_keep_a: assert property (
    !ld_lower |=> lower_limit == $past(lower_limit)
  ) else $error("lower limit changed without load");

  temp_ro_a: assert property (
    accept_wr & sel_data & is_temp
      |=> upper_limit == $past(upper_limit) && lower_limit == $past(lower_limit)
  ) else $error("data write under temperature command landed");

  unmapped_read_a: assert property (
    I_AVS.read & O_AVS_WAITREQUEST & sel_none |=> O_AVS_READDATA == 32'h0000_0000
  ) else $error("unmapped read not zero");

  readdata_hold_a: assert property (
    !(I_AVS.read & O_AVS_WAITREQUEST) |=> $stable(O_AVS_READDATA)
  ) else $error("read data moved without a read");

  either_mode_a: assert property (
    cfg.mode == 2'b11 & I_TIME_ALARM |=> O_ALARM_OUTPUT == $past(cfg.sense)
  ) else $error("time alarm not passed in either mode");

  flag_idle_a: assert property (
    !heat_alarm_flag & ~hot_in |=> !heat_alarm_flag
  ) else $error("flag set without hot sample");

  sense_idle_a: assert property (
    !cfg.sense & cfg.mode == 2'b01 & ~heat_next |=> O_ALARM_OUTPUT
  ) else $error("active-low output not high when inactive");

  flag_latch_a: assert property (
    heat_alarm_flag |-> sticky_heat_latch
  ) else $error("flag set without sticky latch");

  flag_set_c: cover property (set_evt ##[1:500] clr_evt);
  either_mode_c: cover property (cfg.mode == 2'b11 & I_TIME_ALARM);
  temp_poll_c: cover property (I_AVS.read & sel_data & is_temp & ~O_AVS_WAITREQUEST);
  limit_write_c: cover property (ld_upper ##[1:20] ld_lower);
  irq_c: cover property ($rose(O_IRQ));
endmodule
`default_nettype wire

/* File: logic/thermo_defines.svh */
/*
  Offsets, field positions, reset values and command codes of the
  thermostat alarm block. Assumes byte addressing on a 32-bit bus.
*/
`ifndef THERMO_DEFINES_SVH
`define THERMO_DEFINES_SVH

// Register byte offsets
`define OFS_CMD 8'h00
`define OFS_DATA 8'h04
`define OFS_CFG 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10

// Command codes
`define CMD_UPPER_LIMIT 8'hA1
`define CMD_LOWER_LIMIT 8'hA2
`define CMD_READ_TEMP 8'hAA

// Configuration register fields
`define CFG_SENSE_BIT 0
`define CFG_MODE_LO 1
`define CFG_MODE_HI 2
`define CFG_FLAG_BIT 3
`define CFG_LATCH_BIT 4

// Interrupt status bit positions
`define IRQ_FLAG_SET 0
`define IRQ_FLAG_CLR 1
`define IRQ_CONV 2
`define IRQ_W 3

// Reset values
`define CMD_RST 8'h00
`define UPPER_RST 16'h7D00
`define LOWER_RST 16'hC900
`define TEMP_RST 16'h0000
`define SENSE_RST 1'b0
`define MODE_RST 2'b00
`define ALARM_RST 1'b1
`define IRQ_RST 3'h0

`endif

/* File: logic/thermo_pkg.sv */
/*
  Types shared by the thermostat alarm block.
  Assumes the defines header is compiled alongside.
*/
package thermo_pkg;
  typedef struct packed {
    logic valid;
    logic [15:0] temp;
  } conv_s;

  typedef struct packed {
    logic [1:0] mode;
    logic sense;
  } cfg_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } avs_req_s;
endpackage

/* File: logic/heat_comparator.sv */
/*
  Hysteretic heat comparator: alarm flag and sticky latch.
  Assumes conversion results arrive as one-cycle valid pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module heat_comparator (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire thermo_pkg::conv_s i_conv,
  input wire logic [15:0] i_upper,
  input wire logic [15:0] i_lower,
  output logic o_next_flag,
  output logic o_flag,
  output logic o_latch,
  output logic o_set,
  output logic o_clr
);
  import thermo_pkg::*;
  wire hot;
  wire cold;

  assign hot = i_conv.valid & ($signed(i_conv.temp) > $signed(i_upper));
  assign cold = i_conv.valid & ($signed(i_conv.temp) < $signed(i_lower));
  // Crossed limits: setting wins so an alarm is never missed
  assign o_next_flag = hot | (o_flag & ~cold);
  assign o_set = o_next_flag & ~o_flag;
  assign o_clr = o_flag & ~o_next_flag;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_flag <= 1'b0;
      o_latch <= 1'b0;
    end else begin
      o_flag <= o_next_flag;
      // Only a reset clears it
      o_latch <= o_latch | hot;
    end
  end
endmodule
`default_nettype wire

/* File: sim/avs_host.sv */
/*
  Avalon-MM host model that plays the bus controller's part.
  Assumes a slave with registered waitrequest on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module avs_host (
  input wire logic i_clk,
  input wire logic i_wait,
  input wire logic [31:0] i_rdata,
  output var thermo_pkg::avs_req_s o_req
);
  import thermo_pkg::*;
  initial o_req = '0;
  // Limit values go whole, both byte lanes in one beat
  // A short read uses one lane only
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge i_clk);
    o_req <= '{!wr, wr, a, be, d};
    // Held until the answer, however slow
    do @(posedge i_clk); while (i_wait !== 1'b0);
    q = i_rdata;
    o_req <= '0;
  endtask
endmodule
`default_nettype wire

/* File: sim/thermostat_alarm_logic_tb.sv */
/*
  Self-checking bench for the thermostat alarm block.
  Assumes the host model drives the register bus.
*/
`timescale 1ns/10ps
`default_nettype none
`include "thermo_defines.svh"
module thermostat_alarm_logic_tb;
  import thermo_pkg::*;
  logic clk;
  logic arst_n;
  logic time_al;
  conv_s conv;
  avs_req_s req;
  logic [31:0] rdata;
  logic [31:0] q;
  logic waitreq;
  logic alarm;
  logic irq;
  int miscompares;
  int n_checks;
  // Row: mode, sense, time alarm, expected pin, with flag set
  logic [4:0] rows [9] = '{5'b00001, 5'b00100, 5'b01101, 5'b01000,
                           5'b10100, 5'b10111, 5'b10010, 5'b11010, 5'b11101};

  thermostat_alarm_logic i_thermostat_alarm_logic (
    .I_CLK(clk),
    .I_ARST_N(arst_n),
    .I_AVS(req),
    .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(waitreq),
    .I_CONV(conv),
    .I_TIME_ALARM(time_al),
    .O_ALARM_OUTPUT(alarm),
    .O_IRQ(irq)
  );
  avs_host i_avs_host (.i_clk(clk), .i_wait(waitreq), .i_rdata(rdata), .o_req(req));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'h1);
    i_avs_host.xfer(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
    i_avs_host.xfer(1'b0, a, '0, 4'hF, q);
    chk(n, q, e);
  endtask

  // One-cycle valid pulse, then let the outputs land
  task automatic cv(input logic [15:0] t);
    @(posedge clk);
    conv <= '{1'b1, t};
    @(posedge clk);
    conv.valid <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  // Registered outputs trail a config write by a cycle
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    arst_n = 1'b0;
    time_al = 1'b0;
    conv = '0;
    miscompares = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    chk("alarm rst", alarm, 1'h1);
    chk("irq rst", irq, 1'h0);
    chk("wait rst", waitreq, 1'h1);
    rd(`OFS_CFG, "cfg rst", '0);
    wr(`OFS_CMD, `CMD_UPPER_LIMIT);
    rd(`OFS_DATA, "upper rst", `UPPER_RST);
    wr(`OFS_CMD, `CMD_LOWER_LIMIT);
    rd(`OFS_DATA, "lower rst", `LOWER_RST);
    wr(`OFS_DATA, '0, 4'h3);
    wr(`OFS_CMD, `CMD_UPPER_LIMIT);
    wr(`OFS_DATA, 32'h0000_1E00, 4'h3);
    rd(`OFS_DATA, "upper", 32'h0000_1E00);
    wr(`OFS_CMD, `CMD_LOWER_LIMIT);
    rd(`OFS_DATA, "lower", '0);
    $display("limits done");
    wr(`OFS_CFG, 32'h0000_0003);
    cv(16'h1F00);
    chk("alarm hi", alarm, 1'h1);
    rd(`OFS_CFG, "cfg hi", 32'h0000_001B);
    rd(`OFS_IRQ_STATUS, "st hi", 32'h0000_0005);
    chk("irq masked", irq, 1'h0);
    wr(`OFS_IRQ_MASK, 32'h0000_0001);
    settle();
    chk("irq on", irq, 1'h1);
    wr(`OFS_IRQ_STATUS, 32'h0000_0001);
    settle();
    chk("irq off", irq, 1'h0);
    rd(`OFS_IRQ_STATUS, "st w1c", 32'h0000_0004);
    $display("alarm and irq done");
    wr(`OFS_CMD, `CMD_READ_TEMP);
    repeat (2) rd(`OFS_DATA, "temp", 32'h0000_1F00);
    i_avs_host.xfer(1'b0, `OFS_DATA, '0, 4'h2, q);
    chk("temp msb", q[15:8], 8'h1F);
    $display("temp read done");
    for (int i = 0; i < 9; i++) begin
      wr(`OFS_CFG, {29'h0, rows[i][4:2]});
      time_al <= rows[i][1];
      settle();
      chk("mode row", alarm, rows[i][0]);
    end
    $display("mode table done");
    wr(`OFS_CFG, 32'h0000_0003);
    cv(16'h0000);
    rd(`OFS_CFG, "cfg at lower", 32'h0000_001B);
    chk("alarm held", alarm, 1'h1);
    cv(16'hFF00);
    chk("alarm clr", alarm, 1'h0);
    rd(`OFS_CFG, "cfg clr", 32'h0000_0013);
    rd(`OFS_IRQ_STATUS, "st clr", 32'h0000_0006);
    cv(16'h1E00);
    rd(`OFS_CFG, "cfg at upper", 32'h0000_0013);
    $display("hysteresis done");
    wr(`OFS_DATA, 32'h0000_1234, 4'h3);
    rd(`OFS_DATA, "temp ro", 32'h0000_1E00);
    rd(8'h14, "unmapped", '0);
    wr(`OFS_CFG, 32'h0000_0002);
    settle();
    chk("alarm idle lo", alarm, 1'h1);
    cv(16'h1F00);
    chk("alarm act lo", alarm, 1'h0);
    $display("active-low done");
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rd(`OFS_CFG, "cfg rst2", '0);
    chk("alarm rst2", alarm, 1'h1);
    $display("refusal and reset done");
    conclude();
  end
endmodule
`default_nettype wire
